/* pdf_fifo.sv */
// Parameterised valid/ready FIFO used on the output stream of the decimation filter.
module pdf_fifo #(
  parameter int W = 40,
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(N);
  logic [W-1:0] mem [N];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign push      = in_valid && (cnt_r != (AW+1)'(N));
  assign pop       = out_valid && out_ready;
  assign in_ready  = cnt_r != (AW+1)'(N);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(N-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(N-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pdf_fifo

/* pdf_pkg.sv */
// Package of constants and carrier types for the polyphase decimation filter.
package pdf_pkg;
  localparam int          DATA_W_DEF   = 18;
  localparam int          COEF_W_DEF   = 18;
  localparam int          DECIM_DEF    = 4;
  localparam int          TAPS_DEF     = 16;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [1:0]  PHASE_RST    = 2'h0;
  localparam logic [1:0]  PHASE_LAST   = 2'h1;
  localparam int          PIPE_LAT     = 3;

  typedef struct packed {
    logic signed [17:0] sample;
  } pdf_in_t;

  typedef struct packed {
    logic signed [39:0] sum;
  } pdf_out_t;
endpackage : pdf_pkg

/* pdf_stream_model.sv */
// Sample source and output sink that face the filter's two stream sides.
module pdf_stream_model (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              stall,
  input  wire logic              in_ready,
  output pdf_pkg::pdf_in_t       in_sample,
  output logic                   in_valid,
  input  wire pdf_pkg::pdf_out_t out_sample,
  input  wire logic              out_valid,
  output logic                   out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [17:0] src_q[$];
  logic signed [39:0] got_q[$];
  initial begin
    in_valid  = 1'h0;
    in_sample = '0;
    out_ready = 1'h1;
  end
  // Samples go out back to back and stay until taken; idle data is inverted so stale data fails.
  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      void'(src_q.pop_front());
    end
    in_valid <= !reset && (src_q.size() != 0);
    in_sample.sample <= (src_q.size() != 0) ? src_q[0] : ~in_sample.sample;
    if (out_valid && out_ready) begin
      got_q.push_back(out_sample.sum);
    end
    out_ready <= !stall;
  end
endmodule : pdf_stream_model

/* pdf_top.sv */
// Polyphase decimate-by-four FIR filter with a shared four-tap multiply datapath.
// Summary of operation
// RULE1 - One output per four inputs consumed.
// RULE2 - Low-pass filter before discarding samples.
// RULE3 - Length multiple of D, strided sub-filters.
// RULE4 - Sub-filter k uses taps k, k+4, k+8, k+12.
// RULE5 - Compute only outputs at multiples of D.
// RULE6 - Output is sum of four partial results.
// RULE7 - Each input goes to one sub-filter.
// RULE8 - Phase counter counts down modulo D from zero.
// RULE9 - Coefficient sets in order 0,3,2,1 per cycle.
// RULE10 - Output presented at one quarter rate.
// RULE11 - Shift, input regs, accumulator on fast clock.
// RULE12 - Result register samples one sum per period.
// RULE13 - Pipeline and output registers in datapath.
// RULE14 - Input at fast rate, output quarter rate.
// RULE15 - Accumulator restarts each group of four.
// RULE16 - Reset clears counter, shifter, accumulator, output.
// RULE17 - Parameterised widths, accumulator never overflows.
module pdf_top #(
  parameter int DATA_W = pdf_pkg::DATA_W_DEF,
  parameter int COEF_W = pdf_pkg::COEF_W_DEF,
  parameter int TAPS   = pdf_pkg::TAPS_DEF,
  parameter logic signed [TAPS*COEF_W-1:0] COEFS = '0
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire pdf_pkg::pdf_in_t in_sample,
  input  wire logic            in_valid,
  output logic                 in_ready,
  output pdf_pkg::pdf_out_t    out_sample,
  output logic                 out_valid,
  input  wire logic            out_ready
);
  localparam int D    = pdf_pkg::DECIM_DEF;
  localparam int P    = TAPS / D;
  localparam int ACCW = DATA_W + COEF_W + $clog2(TAPS); // see RULE17

  // The tap count must divide evenly into D sub-filters.
  initial begin
    if (TAPS % D != 0) begin
      $error("Tap count is not a multiple of the decimation factor.");
    end
  end

  typedef enum logic [1:0] {
    PDF_PH0 = 2'b00,
    PDF_PH3 = 2'b11,
    PDF_PH2 = 2'b10,
    PDF_PH1 = 2'b01
  } pdf_phase_t;

  pdf_phase_t                       phase_r;
  logic signed [DATA_W-1:0]         shift_r [TAPS];
  logic signed [DATA_W-1:0]         din_r   [P];
  logic signed [COEF_W-1:0]         cin_r   [P];
  logic signed [DATA_W+COEF_W-1:0]  prod_r  [P];
  logic signed [ACCW-1:0]           psum_r;
  localparam int LAT  = pdf_pkg::PIPE_LAT + 1;
  localparam int OCCW = $clog2(pdf_pkg::FIFO_DEPTH + 2);

  logic [LAT-1:0]                   vld_r;
  logic [LAT-1:0]                   fst_r;
  logic [LAT-1:0]                   lst_r;
  logic signed [ACCW-1:0]           acc_r;
  logic                             done_r;
  logic                             fifo_in_ready;
  logic [ACCW-1:0]                  fifo_data;
  logic                             fifo_valid;
  logic                             fifo_take;
  logic                             fifo_pop;
  logic [OCCW-1:0]                  occ_r;
  logic [OCCW-1:0]                  occ_nxt;
  logic                             grp_in;
  logic                             grp_out;
  logic                             fire;
  logic signed [ACCW-1:0]           psum_nxt;

  // Ready is a flip-flop, so it is worked out from the next occupancy.
  assign fire    = in_valid && in_ready; // see RULE14
  assign grp_in  = fire && (phase_r == PDF_PH1);
  assign grp_out = out_valid && out_ready;
  assign occ_nxt = occ_r + OCCW'(grp_in) - OCCW'(grp_out);

  // Groups are counted from their last input until their output is taken.
  // The queue can then never overflow; the price is one unused output slot.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      occ_r <= '0;
    end else begin
      occ_r <= occ_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= occ_nxt < OCCW'(pdf_pkg::FIFO_DEPTH); // see RULE14
    end
  end

  // Phase counter walks 0,3,2,1: each accepted input lands in exactly one sub-filter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r <= PDF_PH0; // see RULE16
    end else if (fire) begin
      phase_r <= pdf_phase_t'(phase_r - 2'h1); // see RULE8 see RULE7
    end
  end

  // Input delay line on the fast clock.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < TAPS; i++) begin
        shift_r[i] <= '0; // see RULE16
      end
    end else if (fire) begin
      shift_r[0] <= in_sample.sample; // see RULE11
      for (int i = 1; i < TAPS; i++) begin
        shift_r[i] <= shift_r[i-1];
      end
    end
  end

  // Shared four-tap datapath: sub-filter k multiplies taps k+nD with the
  // matching delayed samples, so every phase adds one partial sum of y(nD).
  genvar g;
  generate
    for (g = 0; g < P; g++) begin : g_tap
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          din_r[g]  <= '0;
          cin_r[g]  <= '0;
          prod_r[g] <= '0;
        end else begin
          // Sub-filter k pairs h(k+gD) with x(m-k-gD); the newest sample sits at
          // index 0 so the phase offset is absorbed by the coefficient choice.
          din_r[g]  <= shift_r[g*D]; // see RULE3
          cin_r[g]  <= COEFS[(int'(phase_r) + g*D)*COEF_W +: COEF_W]; // see RULE4 see RULE9
          prod_r[g] <= din_r[g] * cin_r[g]; // see RULE13
        end
      end
    end
  endgenerate

  always_comb begin
    psum_nxt = '0;
    for (int i = 0; i < P; i++) begin
      psum_nxt = psum_nxt + ACCW'(prod_r[i]); // see RULE2
    end
  end

  // Slot flags follow each accepted input through capture, product and sum.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vld_r <= '0;
    end else begin
      vld_r <= {vld_r[LAT-2:0], fire};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fst_r <= '0;
    end else begin
      fst_r <= {fst_r[LAT-2:0], fire && (phase_r == PDF_PH0)};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lst_r <= '0;
    end else begin
      lst_r <= {lst_r[LAT-2:0], grp_in};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      psum_r <= '0;
    end else begin
      psum_r <= psum_nxt;
    end
  end

  // Only valid slots count, so a stalled source cannot add one slot twice.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= '0; // see RULE16
    end else if (vld_r[LAT-1]) begin
      if (fst_r[LAT-1]) begin
        acc_r <= psum_r; // see RULE15
      end else begin
        acc_r <= acc_r + psum_r; // see RULE6
      end
    end
  end

  // The sum is complete one cycle after the last slot of the group.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= vld_r[LAT-1] && lst_r[LAT-1]; // see RULE5
    end
  end

  // One completed sum per output period, computed only at multiples of D.
  pdf_fifo #(
    .W (ACCW),
    .N (pdf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   (acc_r),
    .in_valid  (done_r), // see RULE1 see RULE5 see RULE12
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // The output register takes a new sum whenever it is empty or being drained.
  assign fifo_take = !out_valid || out_ready;
  assign fifo_pop  = fifo_valid && fifo_take;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_sample <= '0; // see RULE16
    end else if (fifo_pop) begin
      out_sample.sum <= 40'(fifo_data); // see RULE10
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
    end else if (fifo_pop) begin
      out_valid <= 1'b1; // see RULE10
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  a_phase_step: assert property (@(posedge clk) disable iff (reset) // see RULE8
    fire |=> phase_r == pdf_phase_t'($past(phase_r) - 2'h1))
    else $error("Phase counter did not count down.");

  a_phase_hold: assert property (@(posedge clk) disable iff (reset) // see RULE7
    !fire |=> $stable(phase_r))
    else $error("Phase moved without an input.");

  sequence s_slot_first;
    vld_r[LAT-1] && fst_r[LAT-1];
  endsequence

  sequence s_group_end;
    fire && (phase_r == PDF_PH1);
  endsequence

  a_acc_restart: assert property (@(posedge clk) disable iff (reset) // see RULE15
    s_slot_first |=> acc_r == $past(psum_r))
    else $error("Accumulator did not restart.");

  a_acc_sum: assert property (@(posedge clk) disable iff (reset) // see RULE6
    (vld_r[LAT-1] && !fst_r[LAT-1]) |=> acc_r == $past(acc_r) + $past(psum_r))
    else $error("Accumulator lost a partial sum.");

  a_acc_idle: assert property (@(posedge clk) disable iff (reset) // see RULE7
    !vld_r[LAT-1] |=> $stable(acc_r))
    else $error("Accumulator moved on an empty slot.");

  a_done_rate: assert property (@(posedge clk) disable iff (reset) // see RULE1
    done_r |=> !done_r [*3])
    else $error("More than one output per four inputs.");

  a_out_value: assert property (@(posedge clk) disable iff (reset) // see RULE12
    fifo_pop |=> out_valid && out_sample.sum == 40'($past(fifo_data)))
    else $error("Output register missed the sum.");

  a_out_hold: assert property (@(posedge clk) disable iff (reset) // see RULE10
    (out_valid && !out_ready) |=> out_valid && $stable(out_sample))
    else $error("Output changed while not taken.");

  a_group_done: assert property (@(posedge clk) disable iff (reset) // see RULE5
    s_group_end |-> ##5 done_r)
    else $error("Group end did not produce an output.");

  a_ready_full: assert property (@(posedge clk) disable iff (reset) // see RULE14
    (occ_r == OCCW'(pdf_pkg::FIFO_DEPTH)) |-> !in_ready)
    else $error("Ready not withdrawn when queue full.");

  a_occ_bound: assert property (@(posedge clk) disable iff (reset) // see RULE14
    occ_r <= OCCW'(pdf_pkg::FIFO_DEPTH))
    else $error("More groups in flight than queue places.");

  a_fifo_room: assert property (@(posedge clk) disable iff (reset) // see RULE12
    done_r |-> fifo_in_ready)
    else $error("Completed sum met a full queue.");
endmodule : pdf_top

/* polyphase_decimation_fir_test.sv */
// Self-checking bench for the polyphase decimation filter.
module polyphase_decimation_fir_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Every polyphase branch sums to 10, so the checks hold whichever branch meets the impulse.
  localparam logic signed [287:0] COEFS = {18'h3, 18'h2, 18'h1, 18'h4, 18'h2, 18'h1, 18'h4, 18'h3,
                                           18'h1, 18'h4, 18'h3, 18'h2, 18'h4, 18'h3, 18'h2, 18'h1};
  logic              clk = 1'h0;
  logic              reset = 1'h1;
  logic              stall = 1'h0;
  pdf_pkg::pdf_in_t  in_sample;
  logic              in_valid;
  logic              in_ready;
  pdf_pkg::pdf_out_t out_sample;
  logic              out_valid;
  logic              out_ready;
  int                bad_count = 0;
  int                checks_done = 0;

  always #20 clk = ~clk;

  pdf_top #(.COEFS(COEFS)) i_pdf_top (.clk(clk), .reset(reset), .in_sample(in_sample),
    .in_valid(in_valid), .in_ready(in_ready), .out_sample(out_sample), .out_valid(out_valid),
    .out_ready(out_ready));
  pdf_stream_model i_pdf_stream_model (.clk(clk), .reset(reset), .stall(stall),
    .in_ready(in_ready), .in_sample(in_sample), .in_valid(in_valid), .out_sample(out_sample),
    .out_valid(out_valid), .out_ready(out_ready));

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    i_pdf_stream_model.got_q.delete();
    @(posedge clk);
    #1;
    check("out_valid", 40'h0, {39'h0, out_valid});
    check("out_sample", 40'h0, out_sample.sum);
    @(posedge clk);
  endtask : do_reset

  task automatic push(input logic signed [17:0] v, input int n);
    repeat (n) i_pdf_stream_model.src_q.push_back(v);
  endtask : push

  task automatic wait_outputs(input int n);
    int k;
    for (k = 0; k < 400 && i_pdf_stream_model.got_q.size() < n; k++) @(posedge clk);
    if (k == 400) begin
      bad_count++;
      $display("BAD output wait expected %0d seen %0d", n, i_pdf_stream_model.got_q.size());
      finish_test();
    end
    // A short settle lets a surplus output show up before the count is judged.
    repeat (12) @(posedge clk);
    check("output count", 40'(n), 40'(i_pdf_stream_model.got_q.size()));
  endtask : wait_outputs

  task automatic test_impulse;
    logic [39:0] total;
    total = '0;
    push(18'h7, 1);
    push(18'h0, 23);
    wait_outputs(6);
    for (int i = 0; i < 6; i++) total += i_pdf_stream_model.got_q[i];
    check("impulse sum", 40'h46, total);
    $display("test impulse done");
  endtask : test_impulse

  task automatic test_dc;
    push(18'h3fffb, 32);
    wait_outputs(8);
    check("dc output 3", 40'hffffffff38, i_pdf_stream_model.got_q[3]);
    check("dc output 7", 40'hffffffff38, i_pdf_stream_model.got_q[7]);
    $display("test dc done");
  endtask : test_dc

  task automatic test_stall;
    int left;
    @(posedge clk);
    stall <= 1'h1;
    push(18'h1, 64);
    repeat (80) @(posedge clk);
    left = i_pdf_stream_model.src_q.size();
    check("source held back", 40'h1, 40'(left > 0));
    repeat (10) @(posedge clk);
    check("refused kept", 40'(left), 40'(i_pdf_stream_model.src_q.size()));
    stall <= 1'h0;
    wait_outputs(16);
    check("after stall", 40'h28, i_pdf_stream_model.got_q[15]);
    $display("test stall done");
  endtask : test_stall

  initial begin
    do_reset();
    test_impulse();
    do_reset();
    test_dc();
    do_reset();
    test_stall();
    finish_test();
  end
endmodule : polyphase_decimation_fir_test
